//--- include/ssd_regs.svh
// Purpose: Timing counts and input bit positions for the safety sensor diagnostics block.
// Assumes: One clock of 125 MHz; all slow intervals are counted in 1 ms ticks.
// Notes:   Definitions only; included by bare name.
`ifndef SSD_REGS_SVH
`define SSD_REGS_SVH

// Clock and timebase.
`define SSD_CLK_PERIOD_NS   8
`define SSD_TICK_NS         1000000
`define SSD_TICK_CYCLES     (`SSD_TICK_NS / `SSD_CLK_PERIOD_NS)

// Diagnostic square wave in the limit area.
`define SSD_DIAG_SQ_HZ      2
`define SSD_SQ_HALF_MS      (1000 / (2 * `SSD_DIAG_SQ_HZ))

// Fault delays.
`define SSD_DIAG_DELAY_S    10
`define SSD_DIAG_DELAY_MS   (`SSD_DIAG_DELAY_S * 1000)
`define SSD_SAFE_DELAY_MIN  1
`define SSD_SAFE_DELAY_MS   (`SSD_SAFE_DELAY_MIN * 60000)
`define SSD_ANALYSIS_MS     500

// Red flash code timing.
`define SSD_FLASH_ON_MS     200
`define SSD_FLASH_OFF_MS    200
`define SSD_FLASH_PAUSE_MS  1000

// Self-test dropout repeats at this interval and lasts one tick.
`define SSD_SELFTEST_MS     1000

// Bit positions in the synchronised input vector.
`define SSD_IN_WITHIN_ON    0
`define SSD_IN_WITHIN_OFF   1
`define SSD_IN_AT_LIMIT     2
`define SSD_IN_FLT_CH_A     3
`define SSD_IN_FLT_CH_B     4
`define SSD_IN_FLT_SHORT    5
`define SSD_IN_FLT_TEMP     6
`define SSD_IN_FLT_ACT      7
`define SSD_IN_FLT_INT      8
`define SSD_IN_WIDTH        9

`endif

//--- include/ssd_pkg.sv
// Purpose: Types shared by the safety sensor diagnostics block.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   States are one-hot.
`default_nettype none
package ssd_pkg;

   typedef enum logic [5:0] {
      SSD_IDLE     = 6'h01,
      SSD_ACT      = 6'h02,
      SSD_LIMIT    = 6'h04,
      SSD_ANALYSE  = 6'h08,
      SSD_CODE     = 6'h10,
      SSD_INTERNAL = 6'h20
   } ssd_state_type;

endpackage
`default_nettype wire

//--- rtl/ssd_flasher.sv
// Purpose: Repeating group of equal red pulses followed by a longer dark pause.
// Assumes: tick is a one-cycle pulse every 1 ms; code is 1 to 5 and stable while enabled.
// Notes:   Restarts from a dark state whenever enable drops.
`timescale 1ns/100ps
`default_nettype none
`include "ssd_regs.svh"
module ssd_flasher
   import ssd_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   input  wire logic       tick,
   input  wire logic       enable,
   input  wire logic [2:0] code,
   output var  logic       lit_ff
);

   logic [2:0]  pulse_ff;
   logic [2:0]  nxt_pulse;
   logic [10:0] cnt_ff;
   logic [10:0] nxt_cnt;
   logic        pause_ff;
   logic        nxt_pause;
   logic        nxt_lit;

   // Pulse sequencer; the long pause keeps groups apart so the count can be read.
   always_comb begin
      nxt_pulse = pulse_ff;
      nxt_cnt   = cnt_ff;
      nxt_pause = pause_ff;
      nxt_lit   = lit_ff;
      if (!enable) begin
         nxt_pulse = 3'h0;
         nxt_cnt   = 11'h000;
         nxt_pause = 1'b0;
         nxt_lit   = 1'b0;
      end else if (tick) begin
         if (cnt_ff != 11'h000) begin
            nxt_cnt = cnt_ff - 11'h001;
         end else if (pause_ff || pulse_ff == 3'h0) begin
            nxt_lit   = 1'b1;
            nxt_pulse = 3'h1;
            nxt_pause = 1'b0;
            // The tick that finds the count at zero ends the phase, so each load is one short.
            nxt_cnt   = 11'(`SSD_FLASH_ON_MS - 1);
         end else if (lit_ff) begin
            nxt_lit = 1'b0;
            if (pulse_ff >= code) begin
               nxt_pause = 1'b1;
               nxt_cnt   = 11'(`SSD_FLASH_PAUSE_MS - 1);
            end else begin
               nxt_cnt = 11'(`SSD_FLASH_OFF_MS - 1);
            end
         end else begin
            nxt_lit   = 1'b1;
            nxt_pulse = pulse_ff + 3'h1;
            nxt_cnt   = 11'(`SSD_FLASH_ON_MS - 1);
         end
      end
   end

   // State registers.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pulse_ff <= 3'h0;
         cnt_ff   <= 11'h000;
         pause_ff <= 1'b0;
         lit_ff   <= 1'b0;
      end else begin
         pulse_ff <= nxt_pulse;
         cnt_ff   <= nxt_cnt;
         pause_ff <= nxt_pause;
         lit_ff   <= nxt_lit;
      end
   end

endmodule
`default_nettype wire

//--- rtl/ssd_top.sv
// Purpose: Indicator, diagnostic output and safety channels of a non-contact safety sensor.
// Assumes: Sensing front end and fault detectors deliver asynchronous levels, active high.
// Notes:   All slow intervals run on a 1 ms tick; long counts are parameters.
`timescale 1ns/100ps
`default_nettype none
`include "ssd_regs.svh"
// What this block does
// - Actuator absent, no fault: steady green, diagnostic low, both channels off.
// - Actuator detected in range: steady yellow, both channels on, diagnostic high.
// - Actuator near switching limit: yellow flashes, both channels stay on.
// - Limit area drives diagnostic as a 2 Hz square wave.
// - A flash-coded fault first shows steady red for analysis, then a red flash code.
// - Flashes one to five name the fault; internal error is continuous red.
// - Flash-coded faults keep channels on until persisting one minute.
// - Any fault drops the diagnostic output ten seconds after it arises.
// - Internal error switches both channels off at once.
// - Periodic self-test dropouts of at most 1 ms; monitor ignores them.
// - Detection has hysteresis: on at switch-on point, off beyond switch-off point.
module ssd_top
   import ssd_pkg::*;
#(
   parameter int unsigned TICK_CYCLES   = `SSD_TICK_CYCLES,
   parameter int unsigned DIAG_DELAY_MS = `SSD_DIAG_DELAY_MS,
   parameter int unsigned SAFE_DELAY_MS = `SSD_SAFE_DELAY_MS
)
(
   input  wire logic core_clk,
   input  wire logic arst_n,
   input  wire logic act_within_on,
   input  wire logic act_within_off,
   input  wire logic act_at_limit,
   input  wire logic flt_ch_a,
   input  wire logic flt_ch_b,
   input  wire logic flt_short,
   input  wire logic flt_temp,
   input  wire logic flt_actuator,
   input  wire logic flt_internal,
   output var  logic led_green_ff,
   output var  logic led_yellow_ff,
   output var  logic led_red_ff,
   output var  logic diag_out_ff,
   output var  logic safety_out_a_ff,
   output var  logic safety_out_b_ff
);

   logic [`SSD_IN_WIDTH-1:0] meta_ff;
   logic [`SSD_IN_WIDTH-1:0] in_ff;
   logic [16:0]              tick_cnt_ff;
   logic [16:0]              nxt_tick_cnt;
   logic                     tick_ff;
   logic                     nxt_tick;
   logic [7:0]               sq_cnt_ff;
   logic [7:0]               nxt_sq_cnt;
   logic                     sq_ff;
   logic                     nxt_sq;
   logic [9:0]               st_cnt_ff;
   logic [9:0]               nxt_st_cnt;
   logic                     drop_ff;
   logic                     nxt_drop;
   logic [15:0]              age_ff;
   logic [15:0]              nxt_age;
   logic                     presence_ff;
   logic                     nxt_presence;
   ssd_state_type            state_ff;
   ssd_state_type            nxt_state;
   logic                     any_fault;
   logic                     coded_fault;
   logic [2:0]               fault_code;
   logic                     flash_lit;
   logic                     safe_en;
   logic                     nxt_green;
   logic                     nxt_yellow;
   logic                     nxt_red;
   logic                     nxt_diag;

   // Lowest flash count wins when several coded faults are present at once.
   function automatic logic [2:0] ssd_encode(input logic [`SSD_IN_WIDTH-1:0] v);
      logic [2:0] c;
      c = 3'h0;
      if (v[`SSD_IN_FLT_ACT]) c = 3'h5;
      if (v[`SSD_IN_FLT_TEMP]) c = 3'h4;
      if (v[`SSD_IN_FLT_SHORT]) c = 3'h3;
      if (v[`SSD_IN_FLT_CH_B]) c = 3'h2;
      if (v[`SSD_IN_FLT_CH_A]) c = 3'h1;
      return c;
   endfunction

   // Two-stage synchroniser for all sensing and fault levels.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_ff <= '0;
         in_ff   <= '0;
      end else begin
         meta_ff <= {flt_internal, flt_actuator, flt_temp, flt_short, flt_ch_b,
                     flt_ch_a, act_at_limit, act_within_off, act_within_on};
         in_ff   <= meta_ff;
      end
   end

   assign fault_code  = ssd_encode(in_ff);
   assign coded_fault = (fault_code != 3'h0);
   assign any_fault   = coded_fault | in_ff[`SSD_IN_FLT_INT];

   // Timebase, 2 Hz square wave, self-test schedule and fault age.
   always_comb begin
      nxt_tick     = 1'b0;
      nxt_tick_cnt = tick_cnt_ff + 17'h00001;
      if (tick_cnt_ff == 17'(TICK_CYCLES - 1)) begin
         nxt_tick_cnt = 17'h00000;
         nxt_tick     = 1'b1;
      end
      nxt_sq_cnt = sq_cnt_ff;
      nxt_sq     = sq_ff;
      nxt_st_cnt = st_cnt_ff;
      nxt_drop   = drop_ff;
      nxt_age    = age_ff;
      if (tick_ff) begin
         nxt_sq_cnt = sq_cnt_ff + 8'h01;
         if (sq_cnt_ff == 8'(`SSD_SQ_HALF_MS - 1)) begin
            nxt_sq_cnt = 8'h00;
            nxt_sq     = ~sq_ff;
         end
         // The dropout spans exactly one tick, so it never exceeds 1 ms.
         nxt_st_cnt = st_cnt_ff + 10'h001;
         nxt_drop   = 1'b0;
         if (st_cnt_ff == 10'(`SSD_SELFTEST_MS - 1)) begin
            nxt_st_cnt = 10'h000;
            nxt_drop   = 1'b1;
         end
         if (age_ff != 16'hffff) begin
            nxt_age = age_ff + 16'h0001;
         end
      end
      if (!any_fault) begin
         nxt_age = 16'h0000;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_cnt_ff <= 17'h00000;
         tick_ff     <= 1'b0;
         sq_cnt_ff   <= 8'h00;
         sq_ff       <= 1'b0;
         st_cnt_ff   <= 10'h000;
         drop_ff     <= 1'b0;
         age_ff      <= 16'h0000;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         tick_ff     <= nxt_tick;
         sq_cnt_ff   <= nxt_sq_cnt;
         sq_ff       <= nxt_sq;
         st_cnt_ff   <= nxt_st_cnt;
         drop_ff     <= nxt_drop;
         age_ff      <= nxt_age;
      end
   end

   // Presence with hysteresis: set inside switch-on, cleared only beyond switch-off.
   // Operating state follows presence, limit and fault inputs; internal error outranks all.
   always_comb begin
      nxt_presence = presence_ff;
      if (in_ff[`SSD_IN_WITHIN_ON]) begin
         nxt_presence = 1'b1;
      end else if (!in_ff[`SSD_IN_WITHIN_OFF]) begin
         nxt_presence = 1'b0;
      end
      case (state_ff)
         SSD_ANALYSE: begin
            nxt_state = (age_ff >= 16'(`SSD_ANALYSIS_MS)) ? SSD_CODE : SSD_ANALYSE;
         end
         SSD_CODE: begin
            nxt_state = SSD_CODE;
         end
         default: begin
            nxt_state = state_ff;
         end
      endcase
      if (in_ff[`SSD_IN_FLT_INT]) begin
         nxt_state = SSD_INTERNAL;
      end else if (coded_fault) begin
         if (state_ff != SSD_CODE && state_ff != SSD_ANALYSE) begin
            nxt_state = SSD_ANALYSE;
         end
      end else if (!presence_ff) begin
         nxt_state = SSD_IDLE;
      end else if (in_ff[`SSD_IN_AT_LIMIT]) begin
         nxt_state = SSD_LIMIT;
      end else begin
         nxt_state = SSD_ACT;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         presence_ff <= 1'b0;
         state_ff    <= SSD_IDLE;
      end else begin
         presence_ff <= nxt_presence;
         state_ff    <= nxt_state;
      end
   end

   ssd_flasher ssd_flasher_inst (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .tick     (tick_ff),
      .enable   (state_ff == SSD_CODE),
      .code     (fault_code),
      .lit_ff   (flash_lit)
   );

   // Output decode. The self-test dropout overrides every enabled channel state.
   always_comb begin
      nxt_green  = 1'b0;
      nxt_yellow = 1'b0;
      nxt_red    = 1'b0;
      nxt_diag   = 1'b0;
      safe_en    = 1'b0;
      case (state_ff)
         SSD_IDLE: begin
            nxt_green = 1'b1;
         end
         SSD_ACT: begin
            nxt_yellow = 1'b1;
            nxt_diag   = 1'b1;
            safe_en    = 1'b1;
         end
         SSD_LIMIT: begin
            nxt_yellow = sq_ff;
            nxt_diag   = sq_ff;
            safe_en    = 1'b1;
         end
         SSD_ANALYSE, SSD_CODE: begin
            nxt_red  = (state_ff == SSD_ANALYSE) | flash_lit;
            nxt_diag = presence_ff & (age_ff < 16'(DIAG_DELAY_MS));
            safe_en  = presence_ff & (age_ff < 16'(SAFE_DELAY_MS));
         end
         SSD_INTERNAL: begin
            nxt_red  = 1'b1;
            nxt_diag = presence_ff & (age_ff < 16'(DIAG_DELAY_MS));
            safe_en  = 1'b0;
         end
         default: begin
            nxt_green = 1'b0;
         end
      endcase
   end

   // Both channels switch together; short recognition stays inside this block.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         led_green_ff    <= 1'b0;
         led_yellow_ff   <= 1'b0;
         led_red_ff      <= 1'b0;
         diag_out_ff     <= 1'b0;
         safety_out_a_ff <= 1'b0;
         safety_out_b_ff <= 1'b0;
      end else begin
         led_green_ff    <= nxt_green;
         led_yellow_ff   <= nxt_yellow;
         led_red_ff      <= nxt_red;
         diag_out_ff     <= nxt_diag;
         safety_out_a_ff <= safe_en & ~drop_ff;
         safety_out_b_ff <= safe_en & ~drop_ff;
      end
   end

   default clocking ssd_cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   property p_idle_out;
      state_ff == SSD_IDLE |=> led_green_ff && !diag_out_ff && !safety_out_a_ff && !safety_out_b_ff;
   endproperty
   a_idle_out: assert property (p_idle_out) else $error("Idle outputs wrong.");

   property p_act_out;
      state_ff == SSD_ACT && !drop_ff |=> led_yellow_ff && diag_out_ff && safety_out_a_ff && safety_out_b_ff;
   endproperty
   a_act_out: assert property (p_act_out) else $error("Actuated outputs wrong.");

   property p_limit_safe;
      state_ff == SSD_LIMIT && !drop_ff |=> safety_out_a_ff && safety_out_b_ff && led_yellow_ff == $past(sq_ff);
   endproperty
   a_limit_safe: assert property (p_limit_safe) else $error("Limit channels dropped.");

   property p_limit_diag;
      state_ff == SSD_LIMIT ##1 state_ff == SSD_LIMIT |-> diag_out_ff == $past(sq_ff);
   endproperty
   a_limit_diag: assert property (p_limit_diag) else $error("Limit diagnostic not square.");

   property p_analyse_red;
      state_ff == SSD_ANALYSE |=> led_red_ff && !led_green_ff && !led_yellow_ff;
   endproperty
   a_analyse_red: assert property (p_analyse_red) else $error("Analysis not steady red.");

   property p_coded_hold;
      (state_ff == SSD_ANALYSE || state_ff == SSD_CODE) && presence_ff && !drop_ff
         && age_ff < 16'(SAFE_DELAY_MS) |=> safety_out_a_ff && safety_out_b_ff;
   endproperty
   a_coded_hold: assert property (p_coded_hold) else $error("Coded fault dropped early.");

   property p_diag_delay;
      any_fault && age_ff >= 16'(DIAG_DELAY_MS) && !in_ff[`SSD_IN_FLT_INT] ##1 state_ff == SSD_CODE
         |=> !diag_out_ff;
   endproperty
   a_diag_delay: assert property (p_diag_delay) else $error("Diagnostic not low after delay.");

   property p_internal_off;
      in_ff[`SSD_IN_FLT_INT] |=> ##1 !safety_out_a_ff && !safety_out_b_ff && led_red_ff;
   endproperty
   a_internal_off: assert property (p_internal_off) else $error("Internal error kept channels on.");

   property p_drop_off;
      drop_ff |=> !safety_out_a_ff && !safety_out_b_ff;
   endproperty
   a_drop_off: assert property (p_drop_off) else $error("Self-test dropout missing.");

   property p_hyst;
      presence_ff && in_ff[`SSD_IN_WITHIN_OFF] |=> presence_ff;
   endproperty
   a_hyst: assert property (p_hyst) else $error("Presence lost inside hysteresis.");

endmodule
`default_nettype wire

//--- bench/ssd_monitor_model.sv
// Purpose: Behavioural dual-channel safety monitor on the far side of the sensor.
// Assumes: Both channels are positive-switching normally-open inputs.
// Notes:   Off phases of up to DROP_MAX cycles are taken as self-test and ignored.
`timescale 1ns/100ps
`default_nettype none
module ssd_monitor_model #(
   parameter int unsigned DROP_MAX = 125000
)
(
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic        chan_a,
   input  wire logic        chan_b,
   output var  logic        guard_closed_ff,
   output var  logic [15:0] dropout_cnt_ff
);
   logic [31:0] off_cnt_ff;
   logic [31:0] nxt_off_cnt;
   logic        nxt_guard_closed;
   logic [15:0] nxt_dropout_cnt;

   // Guard closed needs both channels on; no cross-wire test here, shorts are the sensor's job.
   always_comb begin
      nxt_off_cnt = off_cnt_ff;
      nxt_guard_closed = guard_closed_ff;
      nxt_dropout_cnt = dropout_cnt_ff;
      if (chan_a && chan_b) begin
         nxt_guard_closed = 1'b1;
         nxt_off_cnt = '0;
         if (off_cnt_ff != 32'h0 && guard_closed_ff) begin
            nxt_dropout_cnt = dropout_cnt_ff + 16'h0001;
         end
      end else if (off_cnt_ff < DROP_MAX) begin
         nxt_off_cnt = off_cnt_ff + 32'h1;
      end else begin
         nxt_guard_closed = 1'b0;
      end
   end

   // A longer dropout opens the guard, so a slow self-test would be seen as a real opening.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         off_cnt_ff <= '0;
         guard_closed_ff <= 1'b0;
         dropout_cnt_ff <= '0;
      end else begin
         off_cnt_ff <= nxt_off_cnt;
         guard_closed_ff <= nxt_guard_closed;
         dropout_cnt_ff <= nxt_dropout_cnt;
      end
   end
endmodule
`default_nettype wire

//--- bench/ssd_top_bench.sv
// Purpose: Self-checking bench for the safety sensor diagnostics block.
// Assumes: Shortened timebase where one millisecond is TICK clock cycles.
// Notes:   Channels expected on are judged through the monitor model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("mismatch at %0t: %s", $time, m); end end
module ssd_top_bench;
   localparam int TICK = 2;
   localparam int PAUSE_MIN = 600 * TICK;
   logic        core_clk;
   logic        arst_n;
   logic        within_on;
   logic        within_off;
   logic        at_limit;
   logic [5:0]  flt;
   logic        led_green_ff;
   logic        led_yellow_ff;
   logic        led_red_ff;
   logic        diag_out_ff;
   logic        safety_out_a_ff;
   logic        safety_out_b_ff;
   logic        guard_closed_ff;
   logic [15:0] dropout_cnt_ff;
   int          mismatches = 0;
   int          total_checks = 0;

   ssd_top #(.TICK_CYCLES(TICK), .DIAG_DELAY_MS(100), .SAFE_DELAY_MS(300)) ssd_top_inst (
      .core_clk(core_clk), .arst_n(arst_n), .act_within_on(within_on), .act_within_off(within_off),
      .act_at_limit(at_limit), .flt_ch_a(flt[0]), .flt_ch_b(flt[1]), .flt_short(flt[2]),
      .flt_temp(flt[3]), .flt_actuator(flt[4]), .flt_internal(flt[5]),
      .led_green_ff(led_green_ff), .led_yellow_ff(led_yellow_ff), .led_red_ff(led_red_ff),
      .diag_out_ff(diag_out_ff), .safety_out_a_ff(safety_out_a_ff), .safety_out_b_ff(safety_out_b_ff));

   ssd_monitor_model #(.DROP_MAX(TICK)) ssd_monitor_model_inst (
      .core_clk(core_clk), .arst_n(arst_n), .chan_a(safety_out_a_ff), .chan_b(safety_out_b_ff),
      .guard_closed_ff(guard_closed_ff), .dropout_cnt_ff(dropout_cnt_ff));

   // Free-running clock of 8 ns.
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Both channels must always agree, dropouts included.
   always @(negedge core_clk) begin
      if (arst_n === 1'b1) `CHK(safety_out_a_ff, safety_out_b_ff, "channels differ")
   end

   // Inputs change one nanosecond after the edge, so outputs are settled when read.
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic ms(input int n);
      step(n * TICK);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Bounded count of consecutive cycles with the diagnostic output at one level.
   task automatic run_len(input logic lvl, output int n);
      n = 0;
      while (diag_out_ff === lvl && n < 1000 * TICK) begin
         step(1);
         n++;
      end
   endtask

   task automatic test_idle();
      `CHK(led_green_ff, 1'b1, "idle green")
      `CHK(diag_out_ff, 1'b0, "idle diag")
      `CHK(safety_out_a_ff, 1'b0, "idle safety")
   endtask

   task automatic test_actuated();
      within_on = 1'b1;
      within_off = 1'b1;
      ms(10);
      `CHK(led_yellow_ff, 1'b1, "actuated yellow")
      `CHK(led_green_ff, 1'b0, "actuated green")
      `CHK(diag_out_ff, 1'b1, "actuated diag")
      `CHK(guard_closed_ff, 1'b1, "actuated guard")
   endtask

   // Inside the hysteresis band the last decision must hold either way.
   task automatic test_hysteresis();
      within_on = 1'b0;
      ms(10);
      `CHK(led_yellow_ff, 1'b1, "held on in band")
      within_off = 1'b0;
      ms(10);
      `CHK(led_green_ff, 1'b1, "off beyond band")
      `CHK(safety_out_a_ff, 1'b0, "safety off beyond band")
      within_off = 1'b1;
      ms(10);
      `CHK(led_green_ff, 1'b1, "held off in band")
      within_on = 1'b1;
      ms(10);
   endtask

   // Limit area runs longer than one self-test period so dropouts are seen.
   task automatic test_limit();
      int          hi;
      int          lo;
      logic [15:0] d0;
      d0 = dropout_cnt_ff;
      at_limit = 1'b1;
      ms(20);
      run_len(1'b1, hi);
      run_len(1'b0, lo);
      run_len(1'b1, hi);
      run_len(1'b0, lo);
      `CHK(hi >= 249 * TICK && hi <= 251 * TICK, 1'b1, "square high half")
      `CHK(lo >= 249 * TICK && lo <= 251 * TICK, 1'b1, "square low half")
      ms(125);
      `CHK(led_yellow_ff, 1'b1, "yellow flash on")
      ms(250);
      `CHK(led_yellow_ff, 1'b0, "yellow flash off")
      ms(1100);
      `CHK(guard_closed_ff, 1'b1, "limit guard")
      `CHK(dropout_cnt_ff != d0, 1'b1, "no self-test dropout")
      at_limit = 1'b0;
      ms(10);
   endtask

   // Skips to the first dark pause, then counts one group of red pulses.
   task automatic count_group(output int n);
      int low;
      int high;
      int g;
      low = 0;
      high = 0;
      g = 0;
      n = 0;
      while (low < PAUSE_MIN && g < 8000 * TICK) begin
         step(1);
         g++;
         low = (led_red_ff === 1'b0) ? low + 1 : 0;
      end
      low = 0;
      while (low < PAUSE_MIN && g < 8000 * TICK) begin
         step(1);
         g++;
         if (led_red_ff === 1'b1) begin
            high++;
            low = 0;
         end else begin
            if (high > 0) begin
               n++;
               `CHK(high >= 199 * TICK && high <= 201 * TICK, 1'b1, "pulse width")
            end
            high = 0;
            low++;
         end
      end
   endtask

   task automatic test_coded(input int code);
      int n;
      flt[code - 1] = 1'b1;
      ms(50);
      `CHK(led_red_ff, 1'b1, "analysis red")
      `CHK(led_green_ff, 1'b0, "analysis green")
      ms(40);
      `CHK(diag_out_ff, 1'b1, "diag before delay")
      ms(20);
      `CHK(diag_out_ff, 1'b0, "diag after delay")
      ms(180);
      `CHK(guard_closed_ff, 1'b1, "coded fault guard")
      ms(25);
      `CHK(safety_out_a_ff, 1'b0, "coded fault late off")
      ms(175);
      `CHK(led_red_ff, 1'b1, "analysis red late")
      count_group(n);
      `CHK(n, code, "flash count")
      flt = '0;
      ms(20);
      `CHK(guard_closed_ff, 1'b1, "guard after clear")
   endtask

   task automatic test_internal();
      int lows;
      lows = 0;
      flt[5] = 1'b1;
      step(6);
      `CHK(safety_out_a_ff, 1'b0, "internal off a")
      `CHK(safety_out_b_ff, 1'b0, "internal off b")
      `CHK(led_red_ff, 1'b1, "internal red")
      ms(90);
      `CHK(diag_out_ff, 1'b1, "internal diag early")
      ms(20);
      `CHK(diag_out_ff, 1'b0, "internal diag late")
      repeat (1000 * TICK) begin
         step(1);
         if (led_red_ff !== 1'b1) lows++;
      end
      `CHK(lows, 0, "internal red not continuous")
      flt = '0;
      ms(20);
   endtask

   // Main sequence.
   initial begin
      arst_n = 1'b0;
      within_on = 1'b0;
      within_off = 1'b0;
      at_limit = 1'b0;
      flt = '0;
      step(20);
      arst_n = 1'b1;
      ms(5);
      test_idle();
      test_actuated();
      test_hysteresis();
      test_limit();
      for (int c = 1; c <= 5; c++) begin
         test_coded(c);
      end
      test_internal();
      tally_and_finish();
   end

   // Whole run needs about 50000 cycles; this limit leaves ample margin.
   initial begin
      #(90000 * 8);
      mismatches++;
      $display("mismatch at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule
`default_nettype wire
